// *** core/boundary_scan_instruction_logic.v ***
// boundary-scan tap: controller, instruction decode, id, bypass, boundary cells
// assumes the test clock is far slower than mclk (800 ns vs 100 ns)
`timescale 1ns/1ps
`include "scan_port_map.vh"
// Operation
// - id bit 0 is constant one
// - id bits 31:28 hold revision
// - id bits 27:12 part code per width
// - id bits 11:1 manufacturer code
// - extest drives cells, chain selected
// - sample captures pins, chain selected
// - sample also shifts tdi into cells (no separate preload)
// - idload captures id, id selected
// - float: bypass selected, outputs high-z
// - clamp drives cells, bypass selected
// - capture-ir loads 1101
// - bypass opcode selects one bit
// - cells cover all functional pins
// - self reset at power-up, trst optional
module boundary_scan_instruction_logic #(
	parameter NIN = 8,
	parameter NOUT = 8,
	parameter WIDE_ORG = 1'b1
) (
	input wire mclk,
	input wire rstn,
	input wire tck,
	input wire tms,
	input wire tdi,
	input wire trst_n,
	input wire [NIN-1:0] core_in,
	input wire [NOUT-1:0] core_out,
	input wire [NOUT-1:0] core_oe,
	output reg tdo_ff,
	output reg tdo_oe_ff,
	output reg [NIN-1:0] pin_in_ff,
	output reg [NOUT-1:0] pin_out_ff,
	output reg [NOUT-1:0] pin_oe_ff,
	output reg [`IR_WIDTH-1:0] ir_ff,
	output reg [3:0] tap_state_ff
);
// chain runs from tdo: input cells, output data cells, enable cells
localparam NB = NIN + 2 * NOUT;
wire tck_s;
wire tms_s;
wire tdi_s;
wire trst_s;
reg tck_d_ff;
reg [NB-1:0] cell_shift_ff;
reg [NB-1:0] cell_upd_ff;
reg [`ID_WIDTH-1:0] id_shift_ff;
reg [`IR_WIDTH-1:0] ir_shift_ff;
reg byp_ff;
reg [3:0] nxt_state;
reg [`IR_WIDTH-1:0] nxt_ir;
reg sel_chain;
reg sel_id;
reg drive_cells;
reg float_all;
reg nxt_tdo;
wire rise;
wire fall;
wire [`ID_WIDTH-1:0] id_word;
wire [15:0] part_code;
wire [NB-1:0] pins_now;
assign part_code = WIDE_ORG ? `ID_PART_WIDE : `ID_PART_NARROW;
assign id_word = {`ID_REV_VAL, part_code, `ID_MFR_VAL, 1'b1};
// every functional pin has a cell
assign pins_now = {core_oe, core_out, core_in};
sync2 #(.RST_VAL(1'b0)) u_tck (.mclk(mclk), .rstn(rstn), .d(tck), .q_ff(tck_s));
sync2 #(.RST_VAL(1'b1)) u_tms (.mclk(mclk), .rstn(rstn), .d(tms), .q_ff(tms_s));
sync2 #(.RST_VAL(1'b1)) u_tdi (.mclk(mclk), .rstn(rstn), .d(tdi), .q_ff(tdi_s));
sync2 #(.RST_VAL(1'b1)) u_trst (.mclk(mclk), .rstn(rstn), .d(trst_n), .q_ff(trst_s));
// edges seen three mclk edges late, so tck must stay far slower
assign rise = tck_s & ~tck_d_ff;
assign fall = ~tck_s & tck_d_ff;
always @* begin
	sel_chain = 1'b0;
	sel_id = 1'b0;
	drive_cells = 1'b0;
	float_all = 1'b0;
	case (ir_ff)
		`OP_EXTEST: begin
			sel_chain = 1'b1;
			drive_cells = 1'b1;
		end
		`OP_SAMPLE: sel_chain = 1'b1;
		`OP_IDLOAD: sel_id = 1'b1;
		`OP_FLOAT: float_all = 1'b1;
		`OP_CLAMP: drive_cells = 1'b1;
		default: sel_chain = 1'b0;
	endcase
end
always @* begin
	nxt_state = tap_state_ff;
	case (tap_state_ff)
		`TAP_TLR: nxt_state = tms_s ? `TAP_TLR : `TAP_RTI;
		`TAP_RTI: nxt_state = tms_s ? `TAP_SDR : `TAP_RTI;
		`TAP_SDR: nxt_state = tms_s ? `TAP_SIR : `TAP_CDR;
		`TAP_CDR: nxt_state = tms_s ? `TAP_E1DR : `TAP_SHDR;
		`TAP_SHDR: nxt_state = tms_s ? `TAP_E1DR : `TAP_SHDR;
		`TAP_E1DR: nxt_state = tms_s ? `TAP_UDR : `TAP_PDR;
		`TAP_PDR: nxt_state = tms_s ? `TAP_E2DR : `TAP_PDR;
		`TAP_E2DR: nxt_state = tms_s ? `TAP_UDR : `TAP_SHDR;
		`TAP_UDR: nxt_state = tms_s ? `TAP_SDR : `TAP_RTI;
		`TAP_SIR: nxt_state = tms_s ? `TAP_TLR : `TAP_CIR;
		`TAP_CIR: nxt_state = tms_s ? `TAP_E1IR : `TAP_SHIR;
		`TAP_SHIR: nxt_state = tms_s ? `TAP_E1IR : `TAP_SHIR;
		`TAP_E1IR: nxt_state = tms_s ? `TAP_UIR : `TAP_PIR;
		`TAP_PIR: nxt_state = tms_s ? `TAP_E2IR : `TAP_PIR;
		`TAP_E2IR: nxt_state = tms_s ? `TAP_UIR : `TAP_SHIR;
		`TAP_UIR: nxt_state = tms_s ? `TAP_SDR : `TAP_RTI;
		default: nxt_state = `TAP_TLR;
	endcase
end
// instruction moves only when leaving update-ir or in reset
always @* begin
	nxt_ir = ir_ff;
	if (tap_state_ff == `TAP_TLR)
		nxt_ir = `OP_BYPASS;
	else if (tap_state_ff == `TAP_UIR)
		nxt_ir = ir_shift_ff;
end
// tdo source chosen by state and instruction
always @* begin
	if (tap_state_ff == `TAP_SHIR)
		nxt_tdo = ir_shift_ff[0];
	else if (sel_chain)
		nxt_tdo = cell_shift_ff[0];
	else if (sel_id)
		nxt_tdo = id_shift_ff[0];
	else
		nxt_tdo = byp_ff;
end
// mclk reset covers power-up; trst only shortens it
always @(posedge mclk or negedge rstn) begin
	if (!rstn) begin
		tck_d_ff <= 1'b0;
		tap_state_ff <= `TAP_TLR;
		ir_ff <= `OP_BYPASS;
		ir_shift_ff <= `OP_CAPTURE;
		id_shift_ff <= 32'h00000000;
		cell_shift_ff <= {NB{1'b0}};
		cell_upd_ff <= {NB{1'b0}};
		byp_ff <= 1'b0;
		tdo_ff <= 1'b0;
		tdo_oe_ff <= 1'b0;
	end else begin
		tck_d_ff <= tck_s;
		if (!trst_s) begin
			tap_state_ff <= `TAP_TLR;
			ir_ff <= `OP_BYPASS;
			tdo_oe_ff <= 1'b0;
		end else if (rise) begin
			tap_state_ff <= nxt_state;
			ir_ff <= nxt_ir;
			case (tap_state_ff)
				`TAP_CIR: ir_shift_ff <= `OP_CAPTURE;
				`TAP_SHIR: ir_shift_ff <= {tdi_s, ir_shift_ff[`IR_WIDTH-1:1]};
				`TAP_CDR: begin
					byp_ff <= 1'b0;
					if (sel_chain)
						cell_shift_ff <= pins_now;
					if (sel_id)
						id_shift_ff <= id_word;
				end
				`TAP_SHDR: begin
					byp_ff <= tdi_s;
					if (sel_chain)
						cell_shift_ff <= {tdi_s, cell_shift_ff[NB-1:1]};
					if (sel_id)
						id_shift_ff <= {tdi_s, id_shift_ff[`ID_WIDTH-1:1]};
				end
				`TAP_UDR: begin
					if (sel_chain)
						cell_upd_ff <= cell_shift_ff;
				end
				default: byp_ff <= byp_ff;
			endcase
		end else if (fall) begin
			// tdo moves on falling tck, settled well before the next rise
			tdo_ff <= nxt_tdo;
			tdo_oe_ff <= (tap_state_ff == `TAP_SHIR) || (tap_state_ff == `TAP_SHDR);
		end
	end
end
always @(posedge mclk or negedge rstn) begin
	if (!rstn) begin
		pin_in_ff <= {NIN{1'b0}};
		pin_out_ff <= {NOUT{1'b0}};
		pin_oe_ff <= {NOUT{1'b0}};
	end else begin
		pin_in_ff <= drive_cells ? cell_upd_ff[NIN-1:0] : core_in;
		pin_out_ff <= drive_cells ? cell_upd_ff[NIN+NOUT-1:NIN] : core_out;
		if (float_all)
			pin_oe_ff <= {NOUT{1'b0}};
		else if (drive_cells)
			pin_oe_ff <= cell_upd_ff[NB-1:NIN+NOUT];
		else
			pin_oe_ff <= core_oe;
	end
end
endmodule

// *** core/scan_port_map.vh ***
// constants for the boundary-scan instruction logic
// assumes inclusion by the scan port design and bench files
`ifndef SCAN_PORT_MAP_VH
`define SCAN_PORT_MAP_VH
`define OP_EXTEST 4'h0
`define OP_SAMPLE 4'h1
`define OP_IDLOAD 4'h2
`define OP_FLOAT 4'h3
`define OP_CLAMP 4'h8
`define OP_CAPTURE 4'hD
`define OP_BYPASS 4'hF
`define IR_WIDTH 4
`define ID_WIDTH 32
`define ID_REV_HI 31
`define ID_REV_LO 28
`define ID_PART_HI 27
`define ID_PART_LO 12
`define ID_MFR_HI 11
`define ID_MFR_LO 1
`define ID_MARK_BIT 0
`define ID_REV_VAL 4'h1 // arbitrary value
`define ID_PART_WIDE 16'h0A01 // arbitrary value
`define ID_PART_NARROW 16'h0A02 // arbitrary value
`define ID_MFR_VAL 11'h055 // arbitrary value
`define TAP_TLR 4'h0
`define TAP_RTI 4'h1
`define TAP_SDR 4'h2
`define TAP_CDR 4'h3
`define TAP_SHDR 4'h4
`define TAP_E1DR 4'h5
`define TAP_PDR 4'h6
`define TAP_E2DR 4'h7
`define TAP_UDR 4'h8
`define TAP_SIR 4'h9
`define TAP_CIR 4'hA
`define TAP_SHIR 4'hB
`define TAP_E1IR 4'hC
`define TAP_PIR 4'hD
`define TAP_E2IR 4'hE
`define TAP_UIR 4'hF
`endif

// *** core/sync2.v ***
// two-flop synchroniser for a level from outside the mclk domain
// assumes mclk and rstn of the host design
`timescale 1ns/1ps
module sync2 #(
	parameter RST_VAL = 1'b0
) (
	input wire mclk,
	input wire rstn,
	input wire d,
	output reg q_ff
);
reg meta_ff;
always @(posedge mclk or negedge rstn) begin
	if (!rstn) begin
		meta_ff <= RST_VAL;
		q_ff <= RST_VAL;
	end else begin
		meta_ff <= d;
		q_ff <= meta_ff;
	end
end
endmodule

// *** testbench/boundary_scan_instruction_logic_tb_top.sv ***
// self-checking bench for the boundary-scan instruction logic
// assumes scan_ctl drives the test port at 800 ns per tck
`timescale 1ns/1ps
`include "scan_port_map.vh"
module boundary_scan_instruction_logic_tb_top;
	logic mclk, rstn, trst_n;
	logic [7:0] core_in, core_out, core_oe;
	wire tck, tms, tdi, tdo_ff, tdo_oe_ff;
	wire [7:0] pin_in_ff, pin_out_ff, pin_oe_ff;
	wire [3:0] ir_ff, tap_state_ff;
	logic [31:0] q;
	int fail_count = 0;
	int tests_run = 0;
	boundary_scan_instruction_logic #(.NIN(8), .NOUT(8), .WIDE_ORG(1'b1)) DUT (
		.mclk(mclk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
		.core_in(core_in), .core_out(core_out), .core_oe(core_oe), .tdo_ff(tdo_ff),
		.tdo_oe_ff(tdo_oe_ff), .pin_in_ff(pin_in_ff), .pin_out_ff(pin_out_ff),
		.pin_oe_ff(pin_oe_ff), .ir_ff(ir_ff), .tap_state_ff(tap_state_ff));
	scan_ctl ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_ff));
	initial begin
		mclk = 0;
		forever #50 mclk = ~mclk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done;
		if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic t_id;
		ctl.scan(1, `OP_IDLOAD, 4, q);
		chk("ir capture", q[3:0], 4'hD);
		chk("ir", ir_ff, `OP_IDLOAD);
		ctl.scan(0, 0, 32, q);
		chk("id mark", q[0], 1'b1);
		chk("id revision", q[31:28], `ID_REV_VAL);
		chk("id part", q[27:12], `ID_PART_WIDE);
		chk("id maker", q[11:1], `ID_MFR_VAL);
		chk("tdo enable idle", tdo_oe_ff, 1'b0);
	endtask
	task automatic t_pins;
		core_in = 8'hA5;
		core_out = 8'h3C;
		core_oe = 8'hF0;
		ctl.scan(1, `OP_SAMPLE, 4, q);
		ctl.scan(0, 24'h69C35A, 24, q);
		chk("sampled", q[23:0], 24'hF03CA5);
		chk("follow", {pin_oe_ff, pin_out_ff}, 16'hF03C);
		ctl.scan(1, `OP_EXTEST, 4, q);
		chk("extest", {pin_oe_ff, pin_out_ff, pin_in_ff}, 24'h69C35A);
		core_out = 8'h00;
		ctl.scan(1, `OP_CLAMP, 4, q);
		chk("clamp", {pin_oe_ff, pin_out_ff}, 16'h69C3);
	endtask
	task automatic t_byp;
		logic [3:0] ops [13] = '{4'h3, 4'h8, 4'hF, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB,
			4'hC, 4'hE, 4'hD};
		core_out = 8'h5A;
		core_oe = 8'hC3;
		foreach (ops[i]) begin
			ctl.scan(1, ops[i], 4, q);
			ctl.scan(0, 2'b01, 2, q);
			chk("bypass", q[1:0], 2'b10);
			if (i == 0) chk("float", pin_oe_ff, 8'h00);
			if (i == 1) chk("clamp hold", {pin_oe_ff, pin_out_ff}, 16'h69C3);
			if (i > 1) chk("pins", {pin_oe_ff, pin_out_ff}, 16'hC35A);
		end
	endtask
	task automatic t_trst;
		ctl.scan(1, `OP_IDLOAD, 4, q);
		trst_n = 0;
		repeat (4) @(negedge mclk);
		chk("trst", {ir_ff, tap_state_ff}, {`OP_BYPASS, `TAP_TLR});
		trst_n = 1;
		ctl.reset_tap;
		ctl.scan(1, `OP_IDLOAD, 4, q);
		rstn = 0;
		repeat (2) @(negedge mclk);
		rstn = 1;
		repeat (2) @(negedge mclk);
		chk("power-up", {ir_ff, tap_state_ff, tdo_oe_ff}, {`OP_BYPASS, `TAP_TLR, 1'b0});
		ctl.reset_tap;
	endtask
	initial begin
		#5000000;
		fail_count++;
		test_done;
	end
	initial begin
		rstn = 0;
		trst_n = 1;
		core_in = '0;
		core_out = '0;
		core_oe = '0;
		repeat (16) @(negedge mclk);
		rstn = 1;
		repeat (4) @(negedge mclk);
		ctl.reset_tap;
		t_id;
		t_pins;
		t_byp;
		t_trst;
		test_done;
	end
endmodule

// *** testbench/scan_ctl.sv ***
// board test controller model: drives tck, tms and tdi, reads tdo
// assumes callers start each operation just after a falling mclk edge
`timescale 1ns/1ps
module scan_ctl (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	initial begin
		tck = 0;
		tms = 1;
		tdi = 0;
	end
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#400 o = tdo;
		tck = 1;
		#400 tck = 0;
	endtask
	task automatic reset_tap;
		logic o;
		repeat (5) step(1, 0, o);
		step(0, 0, o);
	endtask
	task automatic scan(input logic ir, input logic [31:0] d, input int n, output logic [31:0] q);
		logic o;
		q = '0;
		step(1, 0, o);
		if (ir) step(1, 0, o);
		step(0, 0, o);
		step(0, 0, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, d[i], o);
			q[i] = o;
		end
		// tdi inverted once released
		step(1, ~d[n-1], o);
		step(0, d[n-1], o);
	endtask
endmodule

// *** testbench/scan_port_asserts.sv ***
// checker for the scan port: decode, id shift-out and pin control
// assumes it is bound to the boundary-scan top module
`timescale 1ns/1ps
module scan_port_asserts #(parameter NIN = 8, parameter NOUT = 8) (
	input wire mclk, input wire rstn, input wire tck, input wire tms,
	input wire tdi, input wire trst_n, input wire [NIN-1:0] core_in,
	input wire [NOUT-1:0] core_out, input wire [NOUT-1:0] core_oe,
	input wire tdo_ff, input wire tdo_oe_ff, input wire [NIN-1:0] pin_in_ff,
	input wire [NOUT-1:0] pin_out_ff, input wire [NOUT-1:0] pin_oe_ff,
	input wire [3:0] ir_ff, input wire [3:0] tap_state_ff
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	float_hiz_a: assert property ((ir_ff == 4'h3)[*3] |-> pin_oe_ff == '0)
		else $error("outputs driven under float");
	bypass_follow_a: assert property ((ir_ff == 4'hF)[*3]
		|-> pin_out_ff == $past(core_out))
		else $error("pins not following core");
	reserved_byp_a: assert property ((ir_ff == 4'h5)[*3]
		|-> pin_oe_ff == $past(core_oe))
		else $error("reserved opcode disturbs pins");
	clamp_hold_a: assert property ((ir_ff == 4'h8)[*3] |-> $stable(pin_out_ff))
		else $error("clamped outputs moved");
	ir_capture_a: assert property ($rose(tdo_oe_ff) && tap_state_ff == 4'hB |-> tdo_ff)
		else $error("capture pattern bit0 wrong");
	id_mark_a: assert property ($rose(tdo_oe_ff) && tap_state_ff == 4'h4 && ir_ff == 4'h2
		|-> tdo_ff)
		else $error("id first bit not one");
	trst_reset_a: assert property (!trst_n[*4] |=> tap_state_ff == 4'h0 && ir_ff == 4'hF)
		else $error("test reset ignored");
	ir_update_a: assert property (!$stable(ir_ff)
		|-> $past(tap_state_ff) == 4'hF || ir_ff == 4'hF)
		else $error("instruction changed outside update");
	cover property (ir_ff == 4'h2 && tdo_oe_ff);
	cover property (ir_ff == 4'h3 && pin_oe_ff == '0);
	cover property (!trst_n ##1 tap_state_ff == 4'h0);
endmodule
bind boundary_scan_instruction_logic scan_port_asserts #(.NIN(NIN), .NOUT(NOUT)) u_chk (
	.mclk(mclk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
	.core_in(core_in), .core_out(core_out), .core_oe(core_oe), .tdo_ff(tdo_ff),
	.tdo_oe_ff(tdo_oe_ff), .pin_in_ff(pin_in_ff), .pin_out_ff(pin_out_ff),
	.pin_oe_ff(pin_oe_ff), .ir_ff(ir_ff), .tap_state_ff(tap_state_ff));
